// file: rtl/pin_mux_pkg.sv
// Constants, types and tables shared by the pin function select logic.
// Assumes a single 250 MHz clock and a 32-bit classic Wishbone register bus.
package pin_mux_pkg;

	// ****************************************************************
	// Sizes and bus map
	// ****************************************************************
	localparam int          NUM_PINS      = 32;
	localparam int          NUM_SIGS      = 25;
	localparam int          NUM_IRQ       = 8;
	localparam int          NUM_AN        = 8;
	localparam int          ADR_W         = 8;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [7:0]  LEVEL_REG_OFF = 8'h80;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// ****************************************************************
	// Pin indices (register offset is index * 4)
	// ****************************************************************
	localparam logic [4:0] PIN_P30 = 5'h00;
	localparam logic [4:0] PIN_P31 = 5'h01;
	localparam logic [4:0] PIN_P32 = 5'h02;
	localparam logic [4:0] PIN_P34 = 5'h03;
	localparam logic [4:0] PIN_P36 = 5'h04;
	localparam logic [4:0] PIN_P37 = 5'h05;
	localparam logic [4:0] PIN_P40 = 5'h06;
	localparam logic [4:0] PIN_P54 = 5'h0e;
	localparam logic [4:0] PIN_P55 = 5'h0f;
	localparam logic [4:0] PIN_PA1 = 5'h11;
	localparam logic [4:0] PIN_PA3 = 5'h13;
	localparam logic [4:0] PIN_PA4 = 5'h14;
	localparam logic [4:0] PIN_PA5 = 5'h15;
	localparam logic [4:0] PIN_PB1 = 5'h18;
	localparam logic [4:0] PIN_PB2 = 5'h19;
	localparam logic [4:0] PIN_PB3 = 5'h1a;

	// ****************************************************************
	// Peripheral select codes
	// ****************************************************************
	localparam logic [4:0] SEL_HIZ   = 5'h00;
	localparam logic [4:0] SEL_01    = 5'h01;
	localparam logic [4:0] SEL_02    = 5'h02;
	localparam logic [4:0] SEL_03    = 5'h03;
	localparam logic [4:0] SEL_04    = 5'h04;
	localparam logic [4:0] SEL_05    = 5'h05;
	localparam logic [4:0] SEL_07    = 5'h07;
	localparam logic [4:0] SEL_0A    = 5'h0a;
	localparam logic [4:0] SEL_0B    = 5'h0b;
	localparam logic [4:0] SEL_0D    = 5'h0d;
	localparam logic [4:0] SEL_10    = 5'h10;
	localparam logic [4:0] SEL_TOUCH = 5'h19;
	localparam logic [4:0] SEL_1B    = 5'h1b;
	localparam logic [4:0] SEL_CAN   = 5'h1c;

	// ****************************************************************
	// Peripheral signal indices
	// ****************************************************************
	localparam logic [4:0] SIG_TIMER_CH4B_IO        = 5'h00;
	localparam logic [4:0] SIG_TIMER3_RESET_INPUT   = 5'h01;
	localparam logic [4:0] SIG_OUTPUT_DISABLE_INPUT = 5'h02;
	localparam logic [4:0] SIG_SERIAL1_RECEIVE      = 5'h03;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_2      = 5'h04;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_1      = 5'h05;
	localparam logic [4:0] SIG_SERIAL1_FLOW_CONTROL = 5'h06;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_0      = 5'h07;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_12     = 5'h08;
	localparam logic [4:0] SIG_CAN_TRANSMIT_OUT     = 5'h09;
	localparam logic [4:0] SIG_TIMER_CH4A_IO        = 5'h0a;
	localparam logic [4:0] SIG_TIMER3_OUTPUT        = 5'h0b;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_11     = 5'h0c;
	localparam logic [4:0] SIG_CAN_RECEIVE_IN       = 5'h0d;
	localparam logic [4:0] SIG_TIMER_CH3B_IO        = 5'h0e;
	localparam logic [4:0] SIG_SERIAL5_CLOCK        = 5'h0f;
	localparam logic [4:0] SIG_TIMER_CH4D_IO        = 5'h10;
	localparam logic [4:0] SIG_TIMER5_PHASE_V_CAPT  = 5'h11;
	localparam logic [4:0] SIG_COMPARATOR1_OUTPUT   = 5'h12;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_24     = 5'h13;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_23     = 5'h14;
	localparam logic [4:0] SIG_LOW_POWER_TIMER_OUT  = 5'h15;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_22     = 5'h16;
	localparam logic [4:0] SIG_SPI_SLAVE_SELECT_0   = 5'h17;
	localparam logic [4:0] SIG_TOUCH_CHANNEL_27     = 5'h18;

	// Level a peripheral input sees while no pin feeds it (idle high
	// for active-low and serial idle inputs)
	localparam logic [NUM_SIGS-1:0] SIG_IDLE = 25'h082_004e;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {dir_in, dir_out, dir_bidir} sig_dir_t;

	// Pin control register: bit7 analog, bit6 interrupt, bit5 reserved
	typedef struct packed {
		logic       analog_function_select;
		logic       interrupt_input_select;
		logic       reserved;
		logic [4:0] psel;
	} pin_ctrl_t;

	typedef struct packed {
		logic       valid;
		sig_dir_t   dir;
		logic [4:0] sig;
	} route_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] line;
	} irq_map_t;

endpackage

// file: rtl/port_pin_function_select.sv
// Per-pin function select: 32 pin control registers behind Wishbone,
// routing on-chip peripheral signals, interrupt lines and analog channels
// to package pins. Assumes pad inputs are asynchronous to clk_i and the
// pad ring resolves the pin level from pad_out_o and pad_oe_o.
// Pin k sits at byte offset 4*k; offset 0x80 reads filtered pin levels.
// Unlisted codes leave the pin undriven; software must not rely on it.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_select
	import pin_mux_pkg::*;
(
	// Clock and reset
	input  wire logic                            clk_i,
	input  wire logic                            resetn_i,
	// Wishbone classic slave
	input  wire logic                            wb_cyc_i,
	input  wire logic                            wb_stb_i,
	input  wire logic                            wb_we_i,
	input  wire logic [pin_mux_pkg::ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                      wb_sel_i,
	input  wire logic [31:0]                     wb_dat_i,
	output logic      [31:0]                     wb_dat_o,
	output logic                                 wb_ack_o,
	// Package pins
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_in_i,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] pad_out_o,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] pad_oe_o,
	// On-chip peripherals
	input  wire logic [pin_mux_pkg::NUM_SIGS-1:0] periph_out_i,
	input  wire logic [pin_mux_pkg::NUM_SIGS-1:0] periph_oe_i,
	output logic      [pin_mux_pkg::NUM_SIGS-1:0] periph_in_o,
	// Interrupt lines and analog channel enables
	output logic      [pin_mux_pkg::NUM_IRQ-1:0]  external_interrupt_line_o,
	output logic      [pin_mux_pkg::NUM_AN-1:0]   analog_input_channel_en_o
);
	import pin_mux_pkg::*;

	// ****************************************************************
	// Routing tables
	// ****************************************************************

	// Select code to peripheral signal; anything unlisted stays Hi-Z
	function automatic route_t route_of(input logic [4:0] pin,
	                                    input logic [4:0] code);
		route_t r;
		// Codes without their own direction are two-way signals
		r = '{valid: 1'b1, dir: dir_bidir, sig: SIG_TIMER_CH4B_IO};
		case ({pin, code})
			// Port 3
			{PIN_P30, SEL_01}:    r.sig = SIG_TIMER_CH4B_IO;
			{PIN_P30, SEL_05}:    r = '{1'b1, dir_in, SIG_TIMER3_RESET_INPUT};
			{PIN_P30, SEL_07}:    r = '{1'b1, dir_in, SIG_OUTPUT_DISABLE_INPUT};
			{PIN_P30, SEL_0A}:    r = '{1'b1, dir_in, SIG_SERIAL1_RECEIVE};
			{PIN_P30, SEL_TOUCH}: r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_2};
			{PIN_P31, SEL_01}:    r.sig = SIG_TIMER_CH4D_IO;
			{PIN_P31, SEL_0B}:    r.sig = SIG_SERIAL1_FLOW_CONTROL;
			{PIN_P31, SEL_TOUCH}: r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_1};
			{PIN_P32, SEL_TOUCH}: r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_0};
			// Port 5
			{PIN_P54, SEL_01}:    r.sig = SIG_TIMER_CH4B_IO;
			{PIN_P54, SEL_TOUCH}:
				r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_12};
			{PIN_P54, SEL_CAN}:   r = '{1'b1, dir_out, SIG_CAN_TRANSMIT_OUT};
			{PIN_P55, SEL_01}:    r.sig = SIG_TIMER_CH4D_IO;
			{PIN_P55, SEL_02}:    r.sig = SIG_TIMER_CH4A_IO;
			{PIN_P55, SEL_05}:    r = '{1'b1, dir_out, SIG_TIMER3_OUTPUT};
			{PIN_P55, SEL_TOUCH}: r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_11};
			{PIN_P55, SEL_CAN}:   r = '{1'b1, dir_in, SIG_CAN_RECEIVE_IN};
			// Port A
			{PIN_PA1, SEL_07}:    r.sig = SIG_TIMER_CH3B_IO;
			{PIN_PA1, SEL_0A}:    r.sig = SIG_SERIAL5_CLOCK;
			{PIN_PA3, SEL_03}:    r.sig = SIG_TIMER_CH4D_IO;
			{PIN_PA3, SEL_04}:    r = '{1'b1, dir_in, SIG_TIMER5_PHASE_V_CAPT};
			{PIN_PA4, SEL_0D}:    r.sig = SIG_SPI_SLAVE_SELECT_0;
			{PIN_PA5, SEL_0D}:    r.sig = SIG_SPI_SLAVE_SELECT_0;
			{PIN_PA5, SEL_TOUCH}: r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_27};
			// Port B
			{PIN_PB1, SEL_10},
			{PIN_PB2, SEL_10}:    r = '{1'b1, dir_out, SIG_COMPARATOR1_OUTPUT};
			{PIN_PB1, SEL_TOUCH}: r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_24};
			{PIN_PB2, SEL_TOUCH}: r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_23};
			{PIN_PB3, SEL_1B}:
				r = '{1'b1, dir_out, SIG_LOW_POWER_TIMER_OUT};
			{PIN_PB3, SEL_TOUCH}: r = '{1'b1, dir_out, SIG_TOUCH_CHANNEL_22};
			default:              r.valid = 1'b0; // Hi-Z and reserved
		endcase
		return r;
	endfunction

	// Pins that can feed an external interrupt line
	function automatic irq_map_t irq_of(input logic [4:0] pin);
		irq_map_t m;
		m = '{valid: 1'b1, line: 3'h0};
		case (pin)
			// Port 3
			PIN_P30: m.line = 3'h0;
			PIN_P31: m.line = 3'h1;
			PIN_P32: m.line = 3'h2;
			PIN_P34: m.line = 3'h4;
			PIN_P36: m.line = 3'h2;
			PIN_P37: m.line = 3'h4;
			// Ports A and B
			PIN_PA3: m.line = 3'h6;
			PIN_PA4: m.line = 3'h5;
			PIN_PB1: m.line = 3'h4;
			default: m.valid = 1'b0;
		endcase
		return m;
	endfunction

	// ****************************************************************
	// Registers and wires
	// ****************************************************************
	// Control registers and decoded routes
	pin_ctrl_t             ctrl_reg      [NUM_PINS];
	route_t                route         [NUM_PINS];

	// Pad synchroniser and filtered levels
	logic [NUM_PINS-1:0]   sync1_reg;
	logic [NUM_PINS-1:0]   sync2_reg;
	logic [NUM_PINS-1:0]   sync3_reg;
	logic [NUM_PINS-1:0]   level_reg;

	// Next values of the registered outputs
	logic [NUM_PINS-1:0]   pad_out_next;
	logic [NUM_PINS-1:0]   pad_oe_next;
	logic [NUM_SIGS-1:0]   periph_in_next;
	logic [NUM_IRQ-1:0]    irq_next;
	logic [NUM_AN-1:0]     analog_next;

	// Bus slave
	logic                  ack_reg;
	logic [31:0]           dat_reg;
	logic [31:0]           rd_next;
	logic                  req;
	logic                  ctrl_hit;
	logic                  level_hit;
	logic [4:0]            idx;

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************

	// Word index of the pin control registers; offsets 0x00 to 0x7c
	assign req       = wb_cyc_i & wb_stb_i;
	assign idx       = wb_adr_i[6:2];
	assign ctrl_hit  = ~wb_adr_i[7];
	assign level_hit = ({wb_adr_i[7:2], 2'b00} == LEVEL_REG_OFF);

	// Read mux; unmapped words answer with zero and ignore writes
	always_comb begin
		if (ctrl_hit) begin
			// Reserved bit 5 always reads zero
			rd_next = {24'h00_0000, ctrl_reg[idx][7:6], 1'b0,
			           ctrl_reg[idx].psel};
		end else if (level_hit) begin
			rd_next = level_reg;
		end else begin
			rd_next = UNMAPPED_DATA;
		end
	end

	// Ack one cycle after the request, then drop it for one cycle
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// Read data is caught when the request is taken and stands with ack
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dat_reg <= UNMAPPED_DATA;
		end else if (req && !ack_reg) begin
			dat_reg <= rd_next;
		end
	end

	// Both bus outputs come straight from flip-flops
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// ****************************************************************
	// Per-pin control, synchroniser and drive
	// ****************************************************************
	// One register, decoder and drive mux per pin
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			// Write lands on the ack edge; byte lane 0 carries the field
			// Other words and lane-0-off writes leave it untouched
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					ctrl_reg[gi] <= CTRL_RESET;
				end else if (req && ack_reg && wb_we_i && wb_sel_i[0] &&
				             ctrl_hit && idx == 5'(gi)) begin
					ctrl_reg[gi] <= {wb_dat_i[7:6], 1'b0, wb_dat_i[4:0]};
				end
			end

			// Decoded from the live register: one function at a time
			assign route[gi] = route_of(5'(gi), ctrl_reg[gi].psel);

			// Analog use takes the pin away from every digital driver
			always_comb begin
				pad_out_next[gi] = 1'b0;
				pad_oe_next[gi]  = 1'b0;
				if (!ctrl_reg[gi].analog_function_select &&
				    route[gi].valid) begin
					pad_out_next[gi] = periph_out_i[route[gi].sig];
					case (route[gi].dir)
						dir_out:   pad_oe_next[gi] = 1'b1;
						dir_bidir: pad_oe_next[gi] = periph_oe_i[route[gi].sig];
						default:   pad_oe_next[gi] = 1'b0;
					endcase
				end
			end
		end
	endgenerate

	// Three-stage synchroniser; a level counts once stages two and
	// three agree, so a single-cycle glitch never reaches a peripheral
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= pad_in_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Level changes only once stages two and three agree; slow pins only,
	// a pad change reaches the peripherals five edges later
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			level_reg <= '0;
		end else begin
			level_reg <= (sync2_reg & sync3_reg) |
			             (level_reg & (sync2_reg ^ sync3_reg));
		end
	end

	// ****************************************************************
	// Peripheral inputs, interrupt lines, analog channels
	// ****************************************************************

	// Walk pins from the top so the lowest selected pin wins a shared input
	always_comb begin
		irq_map_t irq_hit;
		irq_hit        = '0;
		periph_in_next = SIG_IDLE;
		irq_next       = '0;
		// Only pins routed to an input or two-way signal feed a peripheral
		for (int p = NUM_PINS - 1; p >= 0; p--) begin
			if (!ctrl_reg[p].analog_function_select && route[p].valid &&
			    route[p].dir != dir_out) begin
				periph_in_next[route[p].sig] = level_reg[p];
			end
		end
		// Lines shared by several pins see the OR of them
		for (int p = 0; p < NUM_PINS; p++) begin
			irq_hit = irq_of(p[4:0]);
			if (ctrl_reg[p].interrupt_input_select &&
			    irq_hit.valid) begin
				irq_next[irq_hit.line] =
					irq_next[irq_hit.line] | level_reg[p];
			end
		end
	end

	// Port 4 pin k feeds converter channel k
	// Analog bits of other pins only force their pads undriven and cut them off from peripheral inputs
	always_comb begin
		for (int k = 0; k < NUM_AN; k++) begin
			analog_next[k] =
				ctrl_reg[PIN_P40 + k[4:0]].analog_function_select;
		end
	end

	// Pad drive is registered so a select change never glitches a pad
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pad_out_o <= '0;
			pad_oe_o  <= '0;
		end else begin
			pad_out_o <= pad_out_next;
			pad_oe_o  <= pad_oe_next;
		end
	end

	// Peripheral inputs; unrouted inputs rest at their idle level
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			periph_in_o <= SIG_IDLE;
		end else begin
			periph_in_o <= periph_in_next;
		end
	end

	// Interrupt lines follow the filtered pin levels
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			external_interrupt_line_o <= '0;
		end else begin
			external_interrupt_line_o <= irq_next;
		end
	end

	// Converter enables; a write shows one edge after it lands
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			analog_input_channel_en_o <= '0;
		end else begin
			analog_input_channel_en_o <= analog_next;
		end
	end

endmodule // port_pin_function_select

`default_nettype wire

// file: bench/pad_ring_model.sv
// Pad ring and board model: resolves each package pin from the block's
// drive and an outside source set by the bench.
// Assumes every pin has an outside source, so no pin ever floats.
`timescale 1ns/1ps
`default_nettype none

module pad_ring_model
	import pin_mux_pkg::*;
(
	// Block side
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_out_i,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe_i,
	// Board side
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] ext_lvl_i,
	output logic      [pin_mux_pkg::NUM_PINS-1:0] pad_lvl_o
);
	// Block drive wins; a released pin shows the outside level at once
	always_comb begin
		pad_lvl_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_lvl_i);
	end
endmodule // pad_ring_model

`default_nettype wire

// file: bench/port_pin_function_select_chk.sv
// Checker for the pin function select block, bound to its top ports.
// Shadows the port 3 pin 0 control register from bus writes.
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_select_chk
	import pin_mux_pkg::*;
(
	// Clock, reset and bus
	input wire logic                                 clk_i,
	input wire logic                                 resetn_i,
	input wire logic                                 wb_cyc_i,
	input wire logic                                 wb_stb_i,
	input wire logic                                 wb_we_i,
	input wire logic [pin_mux_pkg::ADR_W-1:0]        wb_adr_i,
	input wire logic [3:0]                           wb_sel_i,
	input wire logic [31:0]                          wb_dat_i,
	input wire logic [31:0]                          wb_dat_o,
	input wire logic                                 wb_ack_o,
	// Pins, peripherals, interrupt lines
	input wire logic [pin_mux_pkg::NUM_PINS-1:0]     pad_in_i,
	input wire logic [pin_mux_pkg::NUM_PINS-1:0]     pad_out_o,
	input wire logic [pin_mux_pkg::NUM_PINS-1:0]     pad_oe_o,
	input wire logic [pin_mux_pkg::NUM_SIGS-1:0]     periph_out_i,
	input wire logic [pin_mux_pkg::NUM_SIGS-1:0]     periph_oe_i,
	input wire logic [pin_mux_pkg::NUM_SIGS-1:0]     periph_in_o,
	input wire logic [pin_mux_pkg::NUM_IRQ-1:0]      external_interrupt_line_o
);
	logic [7:0] p30_reg;
	logic [3:0] hi_cnt;
	logic [3:0] lo_cnt;
	logic       irq_hi;
	logic       irq_lo;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// Shadow of pin 0 control; reserved bit 5 always reads zero
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			p30_reg <= CTRL_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
			wb_sel_i[0] && wb_adr_i[7:2] == 6'h00) begin
			p30_reg <= wb_dat_i[7:0] & 8'hdf;
		end
	end

	// Run lengths of steady interrupt input; covers the input filter delay
	assign irq_hi = p30_reg[6] && !p30_reg[7] && pad_in_i[0];
	assign irq_lo = !(p30_reg[6] && pad_in_i[0]);
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hi_cnt <= 4'h0;
			lo_cnt <= 4'h0;
		end else begin
			hi_cnt <= !irq_hi ? 4'h0 : (hi_cnt == 4'hf ? hi_cnt : hi_cnt + 4'h1);
			lo_cnt <= !irq_lo ? 4'h0 : (lo_cnt == 4'hf ? lo_cnt : lo_cnt + 4'h1);
		end
	end

	a_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_hiz_select: assert property (
		$past(p30_reg[4:0]) == SEL_HIZ |-> !pad_oe_o[0])
		else $error("pin driven with zero select code");
	a_analog_release: assert property (
		$past(p30_reg[7]) |-> !pad_oe_o[0])
		else $error("analog pin still driven");
	a_route_timer: assert property (
		$past(p30_reg) == 8'h01 |->
		pad_out_o[0] == $past(periph_out_i[SIG_TIMER_CH4B_IO]) &&
		pad_oe_o[0] == $past(periph_oe_i[SIG_TIMER_CH4B_IO]))
		else $error("timer channel not routed to pin");
	a_irq_follow: assert property (hi_cnt >= 4'd8 |-> external_interrupt_line_o[0])
		else $error("interrupt line 0 not following pin");
	a_irq_quiet: assert property (lo_cnt >= 4'd8 |-> !external_interrupt_line_o[0])
		else $error("interrupt line 0 active while off");
	a_read_back: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h00 |->
		wb_dat_o == {24'h0, p30_reg})
		else $error("control read data wrong");
	a_reset_idle: assert property (
		$rose(resetn_i) |-> periph_in_o == SIG_IDLE && pad_oe_o == '0)
		else $error("outputs not idle after reset");
endmodule // port_pin_function_select_chk

`default_nettype wire

// file: bench/port_pin_function_select_test.sv
// Testbench: bus tasks, select code table, interrupt and analog maps.
// Assumes the pad ring model and the checker are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_select_test;
	import pin_mux_pkg::*;
	logic        clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i, external_interrupt_line_o, analog_input_channel_en_o;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd, ext_lvl;
	logic [31:0] pad_in_i, pad_out_o, pad_oe_o;
	logic [24:0] periph_out_i, periph_oe_i, periph_in_o;
	logic [4:0]  pn, cd, sg;
	logic [2:0]  ln;
	logic [1:0]  dr;
	int          error_cnt, checks_done;
	// Pin, code, signal, direction; only listed codes are written
	logic [16:0] route_tbl [26] = '{
		{PIN_P30, SEL_01, SIG_TIMER_CH4B_IO, dir_bidir},
		{PIN_P30, SEL_05, SIG_TIMER3_RESET_INPUT, dir_in},
		{PIN_P30, SEL_07, SIG_OUTPUT_DISABLE_INPUT, dir_in},
		{PIN_P30, SEL_0A, SIG_SERIAL1_RECEIVE, dir_in},
		{PIN_P30, SEL_TOUCH, SIG_TOUCH_CHANNEL_2, dir_out},
		{PIN_P31, SEL_TOUCH, SIG_TOUCH_CHANNEL_1, dir_out},
		{PIN_P31, SEL_0B, SIG_SERIAL1_FLOW_CONTROL, dir_bidir},
		{PIN_P32, SEL_TOUCH, SIG_TOUCH_CHANNEL_0, dir_out},
		{PIN_P54, SEL_TOUCH, SIG_TOUCH_CHANNEL_12, dir_out},
		{PIN_P54, SEL_CAN, SIG_CAN_TRANSMIT_OUT, dir_out},
		{PIN_P55, SEL_02, SIG_TIMER_CH4A_IO, dir_bidir},
		{PIN_P55, SEL_05, SIG_TIMER3_OUTPUT, dir_out},
		{PIN_P55, SEL_TOUCH, SIG_TOUCH_CHANNEL_11, dir_out},
		{PIN_P55, SEL_CAN, SIG_CAN_RECEIVE_IN, dir_in},
		{PIN_PA1, SEL_07, SIG_TIMER_CH3B_IO, dir_bidir},
		{PIN_PA1, SEL_0A, SIG_SERIAL5_CLOCK, dir_bidir},
		{PIN_PA3, SEL_03, SIG_TIMER_CH4D_IO, dir_bidir},
		{PIN_PA3, SEL_04, SIG_TIMER5_PHASE_V_CAPT, dir_in},
		{PIN_PB1, SEL_10, SIG_COMPARATOR1_OUTPUT, dir_out},
		{PIN_PB1, SEL_TOUCH, SIG_TOUCH_CHANNEL_24, dir_out},
		{PIN_PB2, SEL_TOUCH, SIG_TOUCH_CHANNEL_23, dir_out},
		{PIN_PB2, SEL_10, SIG_COMPARATOR1_OUTPUT, dir_out},
		{PIN_PB3, SEL_1B, SIG_LOW_POWER_TIMER_OUT, dir_out},
		{PIN_PB3, SEL_TOUCH, SIG_TOUCH_CHANNEL_22, dir_out},
		{PIN_PA5, SEL_0D, SIG_SPI_SLAVE_SELECT_0, dir_bidir},
		{PIN_PA5, SEL_TOUCH, SIG_TOUCH_CHANNEL_27, dir_out}};
	// Pin to interrupt line
	logic [7:0] irq_tbl [9] = '{{PIN_P30, 3'd0}, {PIN_P31, 3'd1},
		{PIN_P32, 3'd2}, {PIN_P34, 3'd4}, {PIN_P36, 3'd2},
		{PIN_P37, 3'd4}, {PIN_PA3, 3'd6}, {PIN_PA4, 3'd5}, {PIN_PB1, 3'd4}};

	port_pin_function_select dut (.clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.pad_in_i, .pad_out_o, .pad_oe_o, .periph_out_i, .periph_oe_i,
		.periph_in_o, .external_interrupt_line_o, .analog_input_channel_en_o);
	pad_ring_model u_pads (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
		.ext_lvl_i(ext_lvl), .pad_lvl_o(pad_in_i));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// One classic cycle; request held until ack is sampled
	task automatic wb_xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		chk("bus ack", 32'h1, {31'h0, wb_ack_o});
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, a);
		checks_done++;
		if (a !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, a);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Cuts a hang short; the whole run needs about 1400 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		results();
	end

	initial begin
		{resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		{ext_lvl, periph_out_i, periph_oe_i} = '0;
		wb_sel_i = 4'hf;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		// Reset value, read/write, reserved bit, unmapped place
		for (int i = 0; i < 32; i++) begin
			wb_xfer(1'b0, 8'(i * 4), 32'h0, rd);
			chk("ctrl reset", 32'h0, rd);
			wb_xfer(1'b1, 8'(i * 4), 32'hff, rd);
			wb_xfer(1'b0, 8'(i * 4), 32'h0, rd);
			chk("ctrl rw", 32'hdf, rd);
			wb_xfer(1'b1, 8'(i * 4), 32'h0, rd);
		end
		wb_xfer(1'b1, 8'h84, 32'hff, rd);
		wb_xfer(1'b0, 8'h84, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		// Each listed code, each level: drive out if it outputs, then receive in if it inputs
		foreach (route_tbl[i]) begin
			{pn, cd, sg, dr} = route_tbl[i];
			wb_xfer(1'b1, {1'b0, pn, 2'b00}, {27'h0, cd}, rd);
			for (int v = 0; v < 2; v++) begin
				periph_oe_i <= '1;
				periph_out_i <= v ? 25'h1 << sg : ~(25'h1 << sg);
				repeat (3) @(posedge clk_i);
				chk("pad oe", 32'(dr != dir_in), 32'(pad_oe_o[pn]));
				if (dr != dir_in) chk("pad out", 32'(v), 32'(pad_out_o[pn]));
				if (dr == dir_out) continue;
				periph_oe_i <= '0;
				ext_lvl <= v ? 32'h1 << pn : ~(32'h1 << pn);
				repeat (9) @(posedge clk_i);
				chk("periph in", 32'(v), 32'(periph_in_o[sg]));
				chk("pad released", 32'h0, 32'(pad_oe_o[pn]));
			end
			wb_xfer(1'b1, {1'b0, pn, 2'b00}, 32'h0, rd);
			repeat (3) @(posedge clk_i);
			chk("pad hiz", 32'h0, 32'(pad_oe_o[pn]));
		end
		// Interrupt map: off, on at its line, low again
		{ext_lvl, periph_oe_i} <= '0;
		foreach (irq_tbl[i]) begin
			{pn, ln} = irq_tbl[i];
			ext_lvl <= 32'h1 << pn;
			repeat (9) @(posedge clk_i);
			chk("irq off", 32'h0, 32'(external_interrupt_line_o));
			wb_xfer(1'b0, LEVEL_REG_OFF, 32'h0, rd);
			chk("pin levels", 32'h1 << pn, rd);
			wb_xfer(1'b1, {1'b0, pn, 2'b00}, 32'h40, rd);
			repeat (9) @(posedge clk_i);
			chk("irq on", 32'h1 << ln, 32'(external_interrupt_line_o));
			ext_lvl <= '0;
			repeat (9) @(posedge clk_i);
			chk("irq low", 32'h0, 32'(external_interrupt_line_o));
			wb_xfer(1'b1, {1'b0, pn, 2'b00}, 32'h0, rd);
		end
		// Analog channels of port 4, then analog bit over a driving code
		for (int k = 0; k < 8; k++) begin
			wb_xfer(1'b1, 8'((PIN_P40 + k) * 4), 32'h80, rd);
			repeat (3) @(posedge clk_i);
			chk("analog ch", 32'h1 << k, 32'(analog_input_channel_en_o));
			wb_xfer(1'b1, 8'((PIN_P40 + k) * 4), 32'h0, rd);
		end
		periph_oe_i <= '1;
		wb_xfer(1'b1, 8'h00, 32'h81, rd);
		repeat (3) @(posedge clk_i);
		chk("analog hiz", 32'h0, 32'(pad_oe_o[0]));
		results();
	end
endmodule // port_pin_function_select_test

bind port_pin_function_select port_pin_function_select_chk u_chk (.clk_i,
	.resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .pad_in_i, .pad_out_o, .pad_oe_o,
	.periph_out_i, .periph_oe_i, .periph_in_o, .external_interrupt_line_o);

`default_nettype wire
